// ==== common/aacc_pkg.sv ====
// constants and types for the aux converter control block
package aacc_pkg;
	// serial frame
	localparam int FRAME_BITS = 16;
	localparam logic [3:0] MODE_ADDR = 4'h7;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 12;
	localparam int DATA_MSB = 11;
	// dac frame: 4-bit address nibble, 12-bit code (reuses address nibbles 4'h1..4'h3)
	localparam logic [3:0] DAC_ADDR_A = 4'h1;
	localparam logic [3:0] DAC_ADDR_B = 4'h2;
	localparam logic [3:0] DAC_ADDR_C = 4'h3;
	localparam logic [3:0] PWR_ADDR = 4'h4;
	// mode register fields
	localparam int MODE_W = 11;
	localparam int F_START = 0;
	localparam int F_REF = 1;
	localparam int F_INSEL_LO = 2;
	localparam int F_AVG_LO = 4;
	localparam int F_DIV_LO = 7;
	localparam int F_READBACK = 10;
	localparam logic [10:0] MODE_RST = 11'h000;
	// conversion sequence
	localparam logic [3:0] EDGES_PER_CONV = 4'hc;
	localparam logic [3:0] SAMPLE_EDGE = 4'h0;
	localparam logic [3:0] LOAD_EDGE = 4'hb;
	localparam logic [2:0] AVG_CODE_MAX = 3'h5;
	localparam int RESULT_W = 10;
	localparam int SUM_W = 15;
	// dac presets
	localparam int DAC_W = 12;
	localparam logic [11:0] DAC_FREQ_PRESET = 12'h1dd;
	localparam logic [11:0] DAC_ZERO = 12'h000;
	// power states
	typedef enum logic [1:0] {
		AACC_PWR_ACTIVE = 2'b00,
		AACC_PWR_IDLE = 2'b01,
		AACC_PWR_STANDBY = 2'b10,
		AACC_PWR_OFF = 2'b11
	} aacc_pwr_e;
	// conversion states
	typedef enum logic [1:0] {
		AACC_IDLE = 2'b00,
		AACC_BUSY = 2'b01,
		AACC_HOLD = 2'b10
	} aacc_conv_e;
endpackage

// ==== hdl/aacc_clk_div.sv ====
// programmable power-of-two divider producing one-cycle conversion enables
`timescale 1ns/1ps
module aacc_clk_div import aacc_pkg::*; #(
	parameter int CODE_W = 3
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [CODE_W-1:0] div_code,
	output logic tick
);
	localparam int CNT_W = (1 << CODE_W) - 1;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] limit;

	// divisor minus one, 2**code
	assign limit = CNT_W'((1 << div_code) - 1);

	// count only while converting so each conversion starts phase-aligned
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (cnt_q >= limit) begin
			cnt_q <= '0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // aacc_clk_div

// ==== hdl/aacc_ctrl.sv ====
// aux adc sequencing, mode register, serial command port and aux dac codes
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - with the clock stopped all registers, modes and dac outputs hold.
// - aux dac writes accepted in any power state, only while the system clock runs.
// - at reset gain dacs read zero, frequency dac its preset code.
// - power-off forces dac outputs zero; leaving it restores stored codes.
// - standby and idle keep dac outputs at last programmed value.
// - start bit begins a conversion, self-clears at completion, resets zero.
// - start bit writes during a running conversion are ignored.
// - reference select: 0 internal bandgap, 1 analog supply.
// - input select 00 ext a, 01 ext b, 10 half supply, 11 half io.
// - averaging codes give 1,2,4,8,16,32; codes 11x give 32.
// - conversion clock is system clock divided by two to the code.
// - result drives serial output only with readback enable set.
// - one conversion is twelve conversion-clock edges.
// - each averaged conversion also takes twelve edges.
// - sixteen-bit msb-first frames, latched when select rises.
// - serial output high while busy, low once result loaded.
// - no new conversion until previous result shifted out.
module aacc_ctrl import aacc_pkg::*; #(
	parameter int DIV_CODE_W = 3
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic cs_b,
	output logic sdo,
	output logic sdo_oe,
	input wire logic [RESULT_W-1:0] adc_bit_in,
	output logic [1:0] input_select,
	output logic reference_select,
	output logic adc_sample,
	output logic [DAC_W-1:0] frequency_control_dac,
	output logic [DAC_W-1:0] gain_control_dac_a,
	output logic [DAC_W-1:0] gain_control_dac_b,
	output logic [1:0] power_state,
	output logic conv_busy
);
	logic [MODE_W-1:0] mode_q;
	logic [FRAME_BITS-1:0] shift_q;
	logic [4:0] bitcnt_q;
	logic sclk_q, cs_q;
	logic sclk_rise, sclk_fall, cs_rise, cs_fall;
	logic frame_ok, wr_mode, wr_start;
	logic [DAC_W-1:0] dac_a_q, dac_b_q, dac_c_q;
	aacc_pwr_e pwr_q;
	aacc_conv_e st_q;
	logic [3:0] edge_q;
	logic [5:0] nconv_q, nconv_target;
	logic [SUM_W-1:0] sum_q;
	logic [RESULT_W-1:0] result_q;
	logic [FRAME_BITS-1:0] out_q;
	logic tick;
	logic [2:0] avg_code;
	logic unread_q;
	logic reading_q;

	////////////////////////////////////////////////////////////////////////////
	// serial port; pins are taken as synchronous, so edges come from one stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
		end else begin
			sclk_q <= sclk;
			cs_q <= cs_b;
		end
	end
	assign sclk_rise = sclk && !sclk_q;
	assign sclk_fall = !sclk && sclk_q;
	assign cs_rise = cs_b && !cs_q;
	assign cs_fall = !cs_b && cs_q;

	// shift in msb first while selected
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_q <= '0;
			bitcnt_q <= '0;
		end else if (cs_fall) begin
			bitcnt_q <= '0;
		end else if (!cs_b && sclk_rise) begin
			shift_q <= {shift_q[FRAME_BITS-2:0], sdi};
			if (bitcnt_q != 5'(FRAME_BITS))
				bitcnt_q <= bitcnt_q + 1'b1;
		end
	end
	// short frames are dropped rather than half-applied; overlong frames apply their last sixteen bits
	assign frame_ok = cs_rise && (bitcnt_q == 5'(FRAME_BITS));
	assign wr_mode = frame_ok && (shift_q[ADDR_MSB:ADDR_LSB] == MODE_ADDR);
	assign wr_start = wr_mode && shift_q[F_START];

	////////////////////////////////////////////////////////////////////////////
	// mode register; start bit is owned by the sequencer while running
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= MODE_RST;
		end else if (st_q == AACC_BUSY && edge_q == LOAD_EDGE && tick &&
				nconv_q == nconv_target) begin
			mode_q[F_START] <= 1'b0;
		end else if (wr_mode) begin
			mode_q[MODE_W-1:1] <= shift_q[MODE_W-1:1];
			// refused while busy or while a result waits unread
			if (st_q == AACC_IDLE && !unread_q)
				mode_q[F_START] <= shift_q[F_START];
		end
	end
	assign avg_code = mode_q[F_AVG_LO +: 3];
	// codes 11x saturate at 32 conversions
	assign nconv_target = (avg_code > AVG_CODE_MAX) ? 6'h1f :
		6'((1 << avg_code) - 1);

	// mux and reference steer the analog side from the mode fields through one register stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			input_select <= 2'b00;
			reference_select <= 1'b0;
		end else begin
			input_select <= mode_q[F_INSEL_LO +: 2];
			reference_select <= mode_q[F_REF];
		end
	end

	aacc_clk_div #(.CODE_W(DIV_CODE_W)) i_aacc_clk_div (
		.clk(clk),
		.rst_b(rst_b),
		.run(st_q == AACC_BUSY),
		.div_code(mode_q[F_DIV_LO +: DIV_CODE_W]),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// conversion sequencer: 12 edges per conversion, repeated per average
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= AACC_IDLE;
			edge_q <= SAMPLE_EDGE;
			nconv_q <= '0;
			sum_q <= '0;
			result_q <= '0;
			adc_sample <= 1'b0;
		end else begin
			adc_sample <= 1'b0;
			unique case (st_q)
				AACC_IDLE: begin
					if (wr_start && !unread_q) begin
						st_q <= AACC_BUSY;
						edge_q <= SAMPLE_EDGE;
						nconv_q <= '0;
						sum_q <= '0;
					end
				end
				AACC_BUSY: begin
					if (tick) begin
						adc_sample <= (edge_q == SAMPLE_EDGE);
						if (edge_q == LOAD_EDGE) begin
							edge_q <= SAMPLE_EDGE;
							sum_q <= sum_q + SUM_W'(adc_bit_in);
							if (nconv_q == nconv_target) begin
								// mean by shift; count is a power of two
								result_q <= RESULT_W'((sum_q + SUM_W'(adc_bit_in)) >>
									((avg_code > AVG_CODE_MAX) ? AVG_CODE_MAX : avg_code));
								st_q <= AACC_HOLD;
							end else begin
								nconv_q <= nconv_q + 1'b1;
							end
						end else begin
							edge_q <= edge_q + 1'b1;
						end
					end
				end
				AACC_HOLD: begin
					st_q <= AACC_IDLE;
				end
				default: st_q <= AACC_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// result output and busy flag on the serial output
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			unread_q <= 1'b0;
			reading_q <= 1'b0;
			out_q <= '0;
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
			conv_busy <= 1'b0;
		end else begin
			conv_busy <= (st_q == AACC_BUSY);
			if (st_q == AACC_HOLD) begin
				unread_q <= 1'b1;
				out_q <= {result_q, {(FRAME_BITS-RESULT_W){result_q[0]}}};
			end else if (cs_fall && unread_q && mode_q[F_READBACK]) begin
				unread_q <= 1'b0;
			end else if (!cs_b && sclk_fall && mode_q[F_READBACK]) begin
				out_q <= {out_q[FRAME_BITS-2:0], out_q[0]}; // last bit held
			end
			// the result is consumed at select fall, so the read needs its own flag
			if (cs_b)
				reading_q <= 1'b0;
			else if (cs_fall && unread_q && mode_q[F_READBACK])
				reading_q <= 1'b1;
			if (st_q == AACC_BUSY) begin
				sdo_oe <= 1'b1;
				sdo <= 1'b1;
			end else if (!cs_b && ((mode_q[F_READBACK] && unread_q) || reading_q)) begin
				sdo_oe <= 1'b1;
				sdo <= out_q[FRAME_BITS-1];
			end else if (unread_q || st_q == AACC_HOLD) begin
				// low from the load edge on; a gap here would look like a new start
				sdo_oe <= 1'b1;
				sdo <= 1'b0;
			end else begin
				sdo_oe <= 1'b0;
				sdo <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// aux dac codes and power state; codes survive power-off
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dac_a_q <= DAC_FREQ_PRESET;
			dac_b_q <= DAC_ZERO;
			dac_c_q <= DAC_ZERO;
			pwr_q <= AACC_PWR_ACTIVE;
		end else if (frame_ok) begin
			// taken in any power state, no conversion clock needed
			unique case (shift_q[ADDR_MSB:ADDR_LSB])
				DAC_ADDR_A: dac_a_q <= shift_q[DATA_MSB:0];
				DAC_ADDR_B: dac_b_q <= shift_q[DATA_MSB:0];
				DAC_ADDR_C: dac_c_q <= shift_q[DATA_MSB:0];
				PWR_ADDR: pwr_q <= aacc_pwr_e'(shift_q[1:0]);
				default: ;
			endcase
		end
	end
	// outputs register the held codes; with no clock edge nothing moves
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frequency_control_dac <= DAC_FREQ_PRESET;
			gain_control_dac_a <= DAC_ZERO;
			gain_control_dac_b <= DAC_ZERO;
			power_state <= 2'b00;
		end else begin
			power_state <= pwr_q;
			if (pwr_q == AACC_PWR_OFF) begin
				frequency_control_dac <= DAC_ZERO;
				gain_control_dac_a <= DAC_ZERO;
				gain_control_dac_b <= DAC_ZERO;
			end else begin
				frequency_control_dac <= dac_a_q;
				gain_control_dac_a <= dac_b_q;
				gain_control_dac_b <= dac_c_q;
			end
		end
	end
endmodule // aacc_ctrl

// ==== test/aacc_ctrl_props.sv ====
// port checker for the aux converter control block
`timescale 1ns/1ps
module aacc_ctrl_props import aacc_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic [1:0] input_select,
	input wire logic reference_select,
	input wire logic adc_sample,
	input wire logic [DAC_W-1:0] frequency_control_dac,
	input wire logic [DAC_W-1:0] gain_control_dac_a,
	input wire logic [DAC_W-1:0] gain_control_dac_b,
	input wire logic [1:0] power_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [15:0] busy_q;
	// busy run length, saturating so the slowest setting cannot wrap
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) busy_q <= 16'h0000;
		else if (!(sdo_oe && sdo)) busy_q <= 16'h0000;
		else if (busy_q != 16'hffff) busy_q <= busy_q + 16'h0001;
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_rst; $rose(rst_b) |-> frequency_control_dac == DAC_FREQ_PRESET
		&& gain_control_dac_a == DAC_ZERO && gain_control_dac_b == DAC_ZERO; endproperty
	property p_off; power_state == AACC_PWR_OFF && $past(power_state) == AACC_PWR_OFF
		|-> (frequency_control_dac | gain_control_dac_a | gain_control_dac_b) == 12'h000;
	endproperty
	property p_busy; $rose(sdo_oe) && cs_b |-> sdo; endproperty
	property p_len; $fell(sdo) && sdo_oe && cs_b |-> busy_q >= 16'(EDGES_PER_CONV); endproperty
	property p_samp; $rose(sdo_oe && sdo) && cs_b |-> ##[0:300] adc_sample; endproperty
	property p_pulse; adc_sample |=> !adc_sample; endproperty
	property p_ins; $changed(input_select) |-> cs_b; endproperty
	property p_ref; $changed(reference_select) |-> cs_b; endproperty
	property p_frq; $changed(frequency_control_dac) |-> cs_b; endproperty
	a_rst: assert property (p_rst) else $error("dac reset levels wrong");
	a_off: assert property (p_off) else $error("dac not zero when off");
	a_busy: assert property (p_busy) else $error("busy not high at start");
	a_len: assert property (p_len) else $error("conversion too short");
	a_samp: assert property (p_samp) else $error("no sample after start");
	a_pulse: assert property (p_pulse) else $error("sample pulse too long");
	a_ins: assert property (p_ins) else $error("input select moved mid frame");
	a_ref: assert property (p_ref) else $error("reference moved mid frame");
	a_frq: assert property (p_frq) else $error("dac moved mid frame");
	c_done: cover property ($fell(sdo) && sdo_oe && cs_b);
	c_off: cover property (power_state == AACC_PWR_OFF);
	c_start: cover property ($rose(sdo_oe) && cs_b);
endmodule // aacc_ctrl_props

// ==== test/aacc_host.sv ====
// serial host model issuing 16-bit command frames
`timescale 1ns/1ps
module aacc_host (
	input wire logic clk,
	output logic sclk,
	output logic sdi,
	output logic cs_b,
	input wire logic sdo
);
	// idle: clock still, select high, data held high so stray bits hit no register
	initial begin
		sclk = 1'b0;
		sdi = 1'b1;
		cs_b = 1'b1;
	end
	// msb first, data set while sclk low; gap up front keeps select high long enough
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		repeat (8) @(posedge clk);
		cs_b <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi <= w[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			r[i] = sdo;
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		cs_b <= 1'b1;
		sdi <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
endmodule // aacc_host

// ==== test/aacc_ctrl_bench.sv ====
// self-checking bench for the aux converter control block
`timescale 1ns/1ps
module aacc_ctrl_bench import aacc_pkg::*; ;
	logic clk = 1'b0;
	logic clk_run = 1'b1;
	logic busy;
	logic rst_b = 1'b0;
	logic sclk, sdi, cs_b, sdo, sdo_oe, adc_sample, reference_select;
	logic [1:0] input_select, power_state;
	logic [RESULT_W-1:0] adcv = 10'h2a5;
	logic [DAC_W-1:0] dac_f, dac_a, dac_b;
	int fails = 0;
	int checks_done = 0;
	// clk_run low parks the clock where it stands
	always #5 clk = clk_run ? ~clk : clk;
	aacc_ctrl i_aacc_ctrl (.clk, .rst_b, .sclk, .sdi, .cs_b, .sdo, .sdo_oe, .adc_bit_in(adcv),
		.input_select, .reference_select, .adc_sample, .frequency_control_dac(dac_f),
		.gain_control_dac_a(dac_a), .gain_control_dac_b(dac_b), .power_state, .conv_busy(busy));
	aacc_host i_aacc_host (.clk, .sclk, .sdi, .cs_b, .sdo);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [15:0] mw(logic rb, logic [2:0] dv, logic [2:0] av,
		logic [1:0] ins, logic rf, logic st);
		return {MODE_ADDR, 1'b0, rb, dv, av, ins, rf, st};
	endfunction
	// sampled on the falling edge so the design's updates have landed
	task automatic wt(input logic lvl, input int lim, output int c);
		c = 0;
		while ((sdo_oe === 1'b1 && sdo === 1'b1) != lvl && c < lim) begin
			@(negedge clk);
			c++;
		end
		if (c >= lim) begin
			fails++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			conclude();
		end
	endtask
	// start, time the busy phase, then read back if enabled
	task automatic run(input logic [15:0] w, input int n);
		int c;
		logic [15:0] r;
		i_aacc_host.xfer(w, r);
		wt(1'b1, 40, c);
		wt(1'b0, 13000, c);
		chk(16'(c >= n - 6 && c <= n + 12), 16'h0001);
		if (w[F_READBACK]) begin
			i_aacc_host.xfer(16'hffff, r);
			chk(r, {adcv, {6{adcv[0]}}});
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int c;
		logic [15:0] r;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(16'(dac_f), 16'(DAC_FREQ_PRESET));
		chk(16'(dac_a | dac_b), 16'h0000);
		chk(16'({input_select, reference_select}), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			i_aacc_host.xfer(mw(1'b0, 3'h5, 3'h0, 2'(i), i[0], 1'b0), r);
			chk(16'({input_select, reference_select}), 16'({2'(i), i[0]}));
		end
		$display("test mode fields done");
		for (int a = 0; a < 8; a++) begin
			@(posedge clk);
			adcv <= 10'h2a5 + 10'(a);
			run(mw(1'b1, 3'h5, 3'(a), 2'h0, 1'b0, 1'b1), 384 * (a > 4 ? 32 : 1 << a));
		end
		run(mw(1'b1, 3'h6, 3'h0, 2'h0, 1'b0, 1'b1), 768);
		run(mw(1'b1, 3'h7, 3'h0, 2'h0, 1'b0, 1'b1), 1536);
		$display("test conversion timing done");
		i_aacc_host.xfer(mw(1'b1, 3'h6, 3'h0, 2'h0, 1'b0, 1'b1), r);
		i_aacc_host.xfer(mw(1'b1, 3'h6, 3'h0, 2'h3, 1'b1, 1'b0), r);
		chk(16'(sdo_oe === 1'b1 && sdo === 1'b1), 16'h0001);
		chk(16'(busy), 16'h0001);
		chk(16'({input_select, reference_select}), 16'h0007);
		wt(1'b0, 2000, c);
		i_aacc_host.xfer(16'hffff, r);
		chk(r, {adcv, {6{adcv[0]}}});
		$display("test start during busy done");
		run(mw(1'b0, 3'h5, 3'h0, 2'h0, 1'b0, 1'b1), 384);
		i_aacc_host.xfer(mw(1'b0, 3'h5, 3'h0, 2'h0, 1'b0, 1'b1), r);
		repeat (20) @(negedge clk);
		chk(16'(sdo_oe === 1'b1 && sdo === 1'b1), 16'h0000);
		chk(16'(busy), 16'h0000);
		i_aacc_host.xfer(mw(1'b1, 3'h5, 3'h0, 2'h0, 1'b0, 1'b0), r);
		i_aacc_host.xfer(16'hffff, r);
		chk(r, {adcv, {6{adcv[0]}}});
		$display("test refused start done");
		i_aacc_host.xfer({DAC_ADDR_B, 12'h5a3}, r);
		i_aacc_host.xfer({PWR_ADDR, 12'h002}, r);
		chk(16'(power_state), 16'(AACC_PWR_STANDBY));
		chk(16'(dac_a), 16'h05a3);
		i_aacc_host.xfer({PWR_ADDR, 12'h003}, r);
		chk(16'(dac_a), 16'h0000);
		i_aacc_host.xfer({PWR_ADDR, 12'h000}, r);
		chk(16'(dac_a), 16'h05a3);
		$display("test dac power states done");
		// park the clock low, then give the wake-up time before converting
		@(negedge clk);
		clk_run = 1'b0;
		#2003;
		chk(16'(dac_a), 16'h05a3);
		chk(16'(power_state), 16'(AACC_PWR_ACTIVE));
		clk_run = 1'b1;
		repeat (710) @(posedge clk);
		run(mw(1'b1, 3'h5, 3'h0, 2'h0, 1'b0, 1'b1), 384);
		$display("test clock stop done");
		conclude();
	end
endmodule // aacc_ctrl_bench

bind aacc_ctrl aacc_ctrl_props i_aacc_ctrl_props (.clk, .rst_b, .cs_b, .sdo, .sdo_oe,
	.input_select, .reference_select, .adc_sample, .frequency_control_dac,
	.gain_control_dac_a, .gain_control_dac_b, .power_state);
